//--- testbench/rpc_ctrl_props.sv
// assertions on the reset and park control ports
module rpc_ctrl_props
    import rpc_pkg::*;
#(
    parameter int STRAP_CYC = 15,
    parameter int INIT_CYC  = 16
) (
    input wire logic       core_clk,                   // clock
    input wire logic       rstn,                       // sync reset
    input wire logic       power_on_reset_n,           // reset pin
    input wire logic       park_request_n,             // park pin
    input wire logic       host_if_sel_oe_n,           // strap enable
    input wire logic       light_source_select_0,      // select 0
    input wire logic       light_source_select_1,      // select 1
    input wire logic       light_source_select_2,      // select 2
    input wire logic       light_source_select_3,      // select 3
    input wire logic       mirror_array_reset_n,       // array reset
    input wire logic       monitor_converter_clock,    // adc clock
    input wire logic       monitor_converter_data_out, // adc data
    input wire logic       aux_oe_n,                   // other enables
    input wire logic       core_rst_n,                 // internal reset
    input wire logic       init_busy,                  // config running
    input wire logic       init_done,                  // config done
    input wire rpc_port_t  cmd_port,                   // command port
    input wire logic       monitor_port,               // monitor port
    input wire logic       park_active                 // parked
);
    localparam int HI = STRAP_CYC + INIT_CYC + 8;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // reset entry, release and start-up timing
    a_pin_reset: assert property (!power_on_reset_n [*6] |-> !core_rst_n)
        else $error("internal reset not held by pin");
    a_release_sync: assert property ($rose(power_on_reset_n) |->
        !core_rst_n ##1 !core_rst_n) else $error("release not synchronised");
    a_start_busy: assert property ($rose(core_rst_n) |-> ##[0:1] init_busy)
        else $error("self-config did not start");
    a_done_bound: assert property ($rose(core_rst_n) |->
        ##[STRAP_CYC:HI] init_done) else $error("init done out of window");
    // pin levels while the reset pin is held
    a_low_outs: assert property (!power_on_reset_n [*6] |->
        !(light_source_select_0 | light_source_select_1 |
          light_source_select_2 | light_source_select_3 |
          mirror_array_reset_n | monitor_converter_clock |
          monitor_converter_data_out)) else $error("outputs not low");
    a_tristate: assert property (!power_on_reset_n [*6] |->
        aux_oe_n && host_if_sel_oe_n) else $error("pins not tristated");
    // park level and port selection
    a_park_on: assert property (!park_request_n [*7] |-> park_active)
        else $error("park not taken");
    a_park_mirror: assert property (park_active |-> !mirror_array_reset_n)
        else $error("array active while parked");
    a_port_pair: assert property (init_done |-> monitor_port == !cmd_port)
        else $error("monitor port not the other port");
    cover property ($rose(init_done));
    cover property (init_done && park_active);
    cover property (init_done && cmd_port == RPC_PORT_TWI);
endmodule : rpc_ctrl_props

//--- testbench/rpc_mgr_model.sv
// management controller model driving reset and park pins
module rpc_mgr_model (
    input  wire logic core_clk,         // clock
    input  wire logic clk_ok,           // clocks stable
    input  wire logic power_fail,       // power loss seen
    output logic      power_on_reset_n, // reset pin
    output logic      park_request_n    // park pin
);
    int lag = 0;
    initial power_on_reset_n = 1'b0;
    initial park_request_n = 1'b1;
    // release reset a few cycles after clocks settle, park on power loss
    always @(negedge core_clk) begin
        lag <= clk_ok ? lag + 1 : 0;
        power_on_reset_n <= clk_ok && lag >= 3;
        park_request_n <= !power_fail;
    end
endmodule : rpc_mgr_model

//--- testbench/tb.sv
// self-checking bench for the reset and park control block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rpc_pkg::*;
    logic core_clk = 0, rstn = 0, clk_ok = 0, power_fail = 0, strap = 0;
    logic power_on_reset_n, park_request_n, host_if_sel_in;
    logic host_if_sel_oe_n, host_if_sel_out, aux_oe_n, core_rst_n;
    logic light_source_select_0, light_source_select_1;
    logic light_source_select_2, light_source_select_3;
    logic mirror_array_reset_n, monitor_converter_clock;
    logic monitor_converter_data_out, init_busy, init_done;
    logic monitor_port, park_active;
    rpc_port_t cmd_port;
    logic [1:0] exp_q[$];
    int error_cnt = 0, tests_run = 0, k;
    // strap wire: bench pull level unless the block drives it
    assign host_if_sel_in = host_if_sel_oe_n ? strap : host_if_sel_out;
    rpc_mgr_model mgr_u (.*);
    rpc_ctrl #(.STRAP_CYC(15), .INIT_CYC(2)) dut_u (.*);
    task automatic check(string n, logic [6:0] s, logic [6:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial forever #50 core_clk = ~core_clk;
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    // compare the port choice each time self-config completes
    initial forever begin
        @(posedge init_done);
        #1;
        check("port", {cmd_port, monitor_port}, exp_q.pop_front());
    end
    // boots with each strap level, strap change and park cycle
    initial begin
        void'($urandom(32'h1783cb81));
        repeat (20) @(negedge core_clk);
        rstn = 1;
        for (int i = 0; i < 4; i++) begin
            clk_ok = 0;
            strap = (i < 2) ? i[0] : 1'($urandom);
            repeat (8) @(negedge core_clk);
            check("rst", {core_rst_n, aux_oe_n, host_if_sel_oe_n}, 3'h3);
            check("low", {light_source_select_0, light_source_select_1,
                light_source_select_2, light_source_select_3,
                mirror_array_reset_n, monitor_converter_clock,
                monitor_converter_data_out}, 7'h0);
            exp_q.push_back({strap, !strap});
            clk_ok = 1;
            for (k = 0; k < 80 && init_done !== 1'b1; k++) @(negedge core_clk);
            check("run", {aux_oe_n, mirror_array_reset_n, init_busy}, 3'h2);
            strap = !strap;
            repeat (3) @(negedge core_clk);
            check("hold", cmd_port, !strap);
            power_fail = 1;
            repeat (8 + $urandom % 4) @(negedge core_clk);
            check("park", {park_active, mirror_array_reset_n}, 2'h2);
            power_fail = 0;
            repeat (8) @(negedge core_clk);
            check("unpark", {park_active, mirror_array_reset_n}, 2'h1);
        end
        test_done();
    end
endmodule : tb
bind rpc_ctrl rpc_ctrl_props #(.STRAP_CYC(STRAP_CYC), .INIT_CYC(INIT_CYC))
    chk_u (.*);

//--- verilog/rpc_ctrl.sv
// reset and park control: reset release, strap capture and park level
`include "rpc_defs.svh"
module rpc_ctrl #(
    parameter int STRAP_CYC = `RPC_STRAP_CYC,
    parameter int INIT_CYC  = `RPC_INIT_CYC
) (
    input  wire logic          core_clk,          // 10 MHz clock
    input  wire logic          rstn,              // sync reset, active low
    input  wire logic          power_on_reset_n,  // reset pin, low = reset
    input  wire logic          park_request_n,    // park pin, low = park
    input  wire logic          host_if_sel_in,    // host port strap
    output logic               host_if_sel_oe_n,  // strap pin enable, low
    output logic               host_if_sel_out,   // strap pin drive
    output logic               light_source_select_0, // low in reset
    output logic               light_source_select_1, // low in reset
    output logic               light_source_select_2, // low in reset
    output logic               light_source_select_3, // low in reset
    output logic               mirror_array_reset_n,  // low in reset
    output logic               monitor_converter_clock,    // low in reset
    output logic               monitor_converter_data_out, // low in reset
    output logic               aux_oe_n,          // other pins enable, low
    output logic               core_rst_n,        // internal reset, low
    output logic               init_busy,         // self-config running
    output logic               init_done,         // self-config finished
    output rpc_pkg::rpc_port_t cmd_port,          // chosen command port
    output logic               monitor_port,      // other port monitors
    output logic               park_active        // mirror array parked
);
    import rpc_pkg::*;

    logic                  rst_s1_r;
    logic                  rst_s2_r;
    logic                  rst_s3_r;
    logic                  pin_rst_n;
    logic                  park_n_s;
    logic                  strap_s;
    rpc_state_t            state_r;
    logic [`RPC_CNT_W-1:0] cnt_r;

    // last cycle of the strap wait: both the sequencer and the capture use it
    function automatic logic strap_end(rpc_state_t st,
                                       logic [`RPC_CNT_W-1:0] cnt);
        return (st == RPC_ST_STRAP) &&
               (cnt == `RPC_CNT_W'(STRAP_CYC - 1));
    endfunction : strap_end

    // reset pin through three flops; stages two and three must agree
    always_ff @(posedge core_clk) begin
        rst_s1_r <= power_on_reset_n;
        rst_s2_r <= rst_s1_r;
        rst_s3_r <= rst_s2_r;
    end

    // low level is reset, held until release is seen stably [RQ1] [RQ10]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pin_rst_n <= 1'b0;
        end else if (rst_s2_r == rst_s3_r) begin
            pin_rst_n <= rst_s3_r;
        end
    end

    // park and strap inputs each pass through their own filtered synchroniser
    rpc_sync u_park (
        .core_clk (core_clk),
        .in_async (park_request_n),
        .init_val (1'b1),
        .rst_n    (rstn),
        .out_lvl  (park_n_s)
    );
    rpc_sync u_strap (
        .core_clk (core_clk),
        .in_async (host_if_sel_in),
        .init_val (1'b0),
        .rst_n    (rstn),
        .out_lvl  (strap_s)
    );

    // sequence: reset, strap wait, init, run [RQ2] [RQ3]
    always_ff @(posedge core_clk) begin
        if (!rstn || !pin_rst_n) begin
            state_r <= RPC_ST_RESET;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                RPC_ST_RESET: begin
                    state_r <= RPC_ST_STRAP; // release starts config [RQ2]
                    cnt_r   <= '0;
                end
                RPC_ST_STRAP: begin
                    if (strap_end(state_r, cnt_r)) begin
                        state_r <= RPC_ST_INIT; // sample time [RQ8]
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                RPC_ST_INIT: begin
                    if (cnt_r == `RPC_CNT_W'(INIT_CYC - 1)) begin
                        state_r <= RPC_ST_RUN;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                RPC_ST_RUN: begin
                    state_r <= RPC_ST_RUN;
                end
                default: begin
                    state_r <= RPC_ST_RESET;
                end
            endcase
        end
    end

    // strap captured once at the end of the wait [RQ8] [RQ9]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cmd_port     <= RPC_PORT_SPI;
            monitor_port <= 1'b1;
        end else if (strap_end(state_r, cnt_r)) begin
            cmd_port     <= strap_s ? RPC_PORT_TWI : RPC_PORT_SPI; // [RQ9]
            monitor_port <= ~strap_s; // unselected port monitors [RQ9]
        end
    end

    // pin drive: listed outputs low, the rest tristate in reset [RQ4] [RQ5]
    always_ff @(posedge core_clk) begin
        if (!rstn || !pin_rst_n) begin
            light_source_select_0      <= 1'b0; // [RQ4]
            light_source_select_1      <= 1'b0;
            light_source_select_2      <= 1'b0;
            light_source_select_3      <= 1'b0;
            mirror_array_reset_n       <= 1'b0;
            monitor_converter_clock    <= 1'b0;
            monitor_converter_data_out <= 1'b0;
            aux_oe_n                   <= 1'b1; // tristate [RQ5]
            host_if_sel_oe_n           <= 1'b1; // strap tristate [RQ8]
            host_if_sel_out            <= 1'b0;
        end else begin
            light_source_select_0      <= 1'b0;
            light_source_select_1      <= 1'b0;
            light_source_select_2      <= 1'b0;
            light_source_select_3      <= 1'b0;
            mirror_array_reset_n       <= (state_r == RPC_ST_RUN) &&
                                          park_n_s;
            monitor_converter_clock    <= 1'b0;
            monitor_converter_data_out <= 1'b0;
            aux_oe_n                   <= (state_r != RPC_ST_RUN);
            host_if_sel_oe_n           <= 1'b1;
            host_if_sel_out            <= 1'b0;
        end
    end

    // internal reset and status flags [RQ10]
    always_ff @(posedge core_clk) begin
        if (!rstn || !pin_rst_n) begin
            core_rst_n  <= 1'b0;
            init_busy   <= 1'b0;
            init_done   <= 1'b0;
        end else begin
            core_rst_n  <= 1'b1;
            init_busy   <= (state_r == RPC_ST_STRAP) ||
                           (state_r == RPC_ST_INIT);
            init_done   <= (state_r == RPC_ST_RUN);
        end
    end

    // low park input parks the mirror array, high unparks [RQ6] [RQ7]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            park_active <= 1'b1;
        end else begin
            park_active <= ~park_n_s;
        end
    end
endmodule : rpc_ctrl

//--- verilog/rpc_defs.svh
// constants for the reset and park control block
// Overview of operation
// (RQ1) low reset input means reset
// (RQ2) reset release starts self-configuration sequence
// (RQ3) outside holds reset until clocks stable
// (RQ4) reset drives listed outputs low
// (RQ5) reset tristates all other outputs
// (RQ6) park input low parks, high unparks
// (RQ7) manager drives park on power loss
// (RQ8) straps tristated, sampled 1.5 us after release
// (RQ9) host strap picks serial or two-wire port
// (RQ10) reset asserts async, releases through sync; the code also asserts reset through the synchroniser
`ifndef RPC_DEFS_SVH
`define RPC_DEFS_SVH
`define RPC_CLK_HZ        10000000
`define RPC_STRAP_NS      1500
`define RPC_STRAP_CYC     ((`RPC_STRAP_NS * (`RPC_CLK_HZ / 1000000) + 999) / 1000)
`define RPC_INIT_CYC      16
`define RPC_CNT_W         8
`endif

//--- verilog/rpc_pkg.sv
// types for the reset and park control block
package rpc_pkg;
    typedef enum logic [2:0] {
        RPC_ST_RESET = 3'h0,
        RPC_ST_STRAP = 3'h1,
        RPC_ST_INIT  = 3'h3,
        RPC_ST_RUN   = 3'h2
    } rpc_state_t;
    typedef enum logic {
        RPC_PORT_SPI = 1'b0,
        RPC_PORT_TWI = 1'b1
    } rpc_port_t;
endpackage : rpc_pkg

//--- verilog/rpc_sync.sv
// three-stage synchroniser with agreement filter
module rpc_sync (
    input  wire logic core_clk, // system clock
    input  wire logic in_async, // asynchronous level
    input  wire logic init_val, // value held in reset
    input  wire logic rst_n,    // synchronous reset, active low
    output logic      out_lvl   // filtered level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // three flops; level changes once stage two and three agree
    always_ff @(posedge core_clk) begin
        s1_r <= in_async;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    // filtered level starts from the pin's idle level, so no false edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_lvl <= init_val;
        end else if (s2_r == s3_r) begin
            out_lvl <= s3_r;
        end
    end
endmodule : rpc_sync
